// file: pkg/qps_pkg.sv
// constants for the quad port controller two-wire slave
package qps_pkg;
  // fixed upper address bits 0,1,0 above the four straps
  localparam logic [2:0] ADDR_FIXED = 3'h2;
  localparam int ADDR_STRAP_LSB = 0;
  localparam int ADDR_STRAP_W = 4;
  // global broadcast address (7-bit)
  localparam logic [6:0] ADDR_GLOBAL = 7'h30;
  // clock and timing
  localparam int CLK_HZ = 25000000;
  localparam int CLK_NS = 40;
  // longest stretch of the clock line in the acknowledge slot, in ns
  localparam int STRETCH_MAX_NS = 10000;
  localparam int STRETCH_MAX_CYC = STRETCH_MAX_NS / CLK_NS;
  // readiness time after reset, in ms
  localparam int READY_MS = 100;
  localparam int READY_CYC = READY_MS * (CLK_HZ / 1000);
  // power-up port mode encodings
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  // bit counting
  localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

// file: rtl/qps_sync.sv
// two-flop synchroniser for the bus and strap pins
`timescale 1ns/1ps
module qps_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // qps_sync

// file: rtl/qps_timer.sv
// down-counter that raises done when a loaded count runs out
`timescale 1ns/1ps
module qps_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [W-1:0] count,
  input wire logic run,
  output logic done
);
  logic [W-1:0] cnt_r;

  initial begin
    if (W < 2) $error("qps_timer width too small");
  end

  // count down while running; done holds until next load
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      done <= 1'b0;
    end else if (load) begin
      cnt_r <= count;
      done <= 1'b0;
    end else if (run && !done) begin
      if (cnt_r == '0) begin
        done <= 1'b1;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // qps_timer

// file: rtl/qps_i2c_slave.sv
// two-wire management slave port of the quad port controller
`timescale 1ns/1ps
// What this block does
// RQ1: byte-wide two-wire slave, management bus compatible, plain master compatible.
// RQ2: frame is start, address with direction, data bytes, then stop.
// RQ3: receiver acks each byte by pulling data low; high is nack.
// RQ4: direction bit one reads from device, zero writes to it.
// RQ5: master starts; device acks each written byte before the next.
// RQ6: device sends read bytes; master nack ends the read.
// RQ7: master ends each transaction with stop, freeing the bus.
// RQ8: device may hold clock low to gain time.
// RQ9: no alert response address support; host polls devices.
// RQ10: address is 0,1,0 then four straps in bits four to one.
// RQ11: straps captured once after reset, used as address thereafter.
// RQ12: also answers global broadcast address 0x30.
// RQ13: host avoids global reads; no arbitration is done here.
// RQ14: host uses only valid strap settings.
// RQ15: power-up port mode auto or shutdown, set by build parameter.
// RQ16: stretching in the acknowledge slot lasts at most ten microseconds.
// RQ17: bus ready within 100 ms of reset.
// RQ18: unmatched addresses get no ack and data stays released.
// RQ19: stop mid-transaction returns to idle, start restarts the address phase, dropping partial byte.
module qps_i2c_slave #(
  parameter int READY_CYCLES = qps_pkg::READY_CYC,
  parameter int STRETCH_CYCLES = 8,
  parameter bit PWRUP_AUTO = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // two-wire bus pins, enables low while driving low
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // address straps
  input wire logic addr_strap_3,
  input wire logic addr_strap_2,
  input wire logic addr_strap_1,
  input wire logic addr_strap_0,
  // register side: write path
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic wr_first,
  output logic wr_global,
  // register side: read path
  input wire logic [7:0] rd_data,
  input wire logic rd_data_ok,
  output logic rd_req,
  // status
  output logic ready,
  output logic busy,
  output logic [1:0] pwrup_mode
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_IGNORE
  } qps_state_t;

  localparam int RDY_W = $clog2(READY_CYCLES + 1) + 1;
  localparam int STR_W = $clog2(qps_pkg::STRETCH_MAX_CYC + 1) + 1;

  initial begin
    if (STRETCH_CYCLES < 1 || STRETCH_CYCLES > qps_pkg::STRETCH_MAX_CYC)
      $error("stretch length out of range");
    if (READY_CYCLES < 3) $error("ready count must cover the strap synchroniser");
  end

  // address byte decode, used for the strap and global compare
  function automatic logic addr_hit(input logic [7:0] b, input logic [3:0] s);
    addr_hit = (b[7:1] == {qps_pkg::ADDR_FIXED, s}) || (b[7:1] == qps_pkg::ADDR_GLOBAL);
  endfunction

  logic scl_s, sda_s, scl_d_r, sda_d_r;
  logic [3:0] strap_s;
  logic [3:0] addr_r;
  logic strap_taken_r;
  qps_state_t state_r;
  logic [2:0] bit_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic rw_r, global_r, first_r;
  logic stretch_r;
  logic str_done;
  logic rdy_done;
  logic start_ev, stop_ev, scl_rise, scl_fall;

  qps_sync #(.W(2), .INIT(2'h3)) u_sync_bus (
    .clk(clk),
    .rst(rst),
    .d({scl_i, sda_i}),
    .q({scl_s, sda_s})
  );

  qps_sync #(.W(4), .INIT(4'h0)) u_sync_strap (
    .clk(clk),
    .rst(rst),
    .d({addr_strap_3, addr_strap_2, addr_strap_1, addr_strap_0}),
    .q(strap_s)
  );

  // ready timer, never loaded, so done rises one cycle after reset
  qps_timer #(.W(RDY_W)) u_ready (
    .clk(clk),
    .rst(rst),
    .load(1'b0),
    .count('0),
    .run(1'b1),
    .done(rdy_done)
  );

  // stretch limit timer, reloaded on every cycle while no stretch is in progress
  qps_timer #(.W(STR_W)) u_stretch (
    .clk(clk),
    .rst(rst),
    .load(!stretch_r),
    .count(STR_W'(STRETCH_CYCLES - 1)),
    .run(stretch_r),
    .done(str_done)
  );

  // edge history of the synchronised lines
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // RQ2 start and stop
  assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;

  // RQ11 strap capture
  // straps sampled once at the end of the ready delay, long after the
  // synchroniser has flushed its reset value, never again
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r <= 4'h0;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r && rdy_done && ready_r) begin
      addr_r <= strap_s;
      strap_taken_r <= 1'b1;
    end
  end

  // RQ17 ready flag
  // the ready timer is never loaded and is done at once; count up from zero to the full count here
  logic [RDY_W-1:0] rdy_cnt_r;
  logic ready_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      rdy_cnt_r <= '0;
      ready_r <= 1'b0;
    end else if (!ready_r) begin
      if (rdy_cnt_r == RDY_W'(READY_CYCLES - 1)) begin
        ready_r <= 1'b1;
      end else begin
        rdy_cnt_r <= rdy_cnt_r + 1'b1;
      end
    end
  end

  // RQ1 byte-wide transfers
  // main protocol machine
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      bit_r <= 3'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      global_r <= 1'b0;
      first_r <= 1'b0;
    // RQ19 abort on framing
    end else if (!ready_r || !strap_taken_r) begin
      state_r <= ST_IDLE;
    end else if (stop_ev) begin
      state_r <= ST_IDLE;
    end else if (start_ev) begin
      state_r <= ST_ADDR;
      bit_r <= 3'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          bit_r <= 3'h0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_r <= bit_r + 3'h1;
            if (bit_r == qps_pkg::BIT_LAST) begin
              // RQ10 strapped match
              // RQ12 global match
              // RQ18 no match
              if (addr_hit({shift_r[6:0], sda_s}, addr_r)) begin
                state_r <= ST_ADDR_ACK;
                // RQ4 direction bit
                rw_r <= sda_s;
                global_r <= (shift_r[6:0] == qps_pkg::ADDR_GLOBAL);
                first_r <= 1'b1;
              end else begin
                state_r <= ST_IGNORE;
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          // first fall closes the address byte, second fall closes the ack slot
          if (scl_fall) begin
            if (bit_r == 3'h0) begin
              bit_r <= 3'h1;
            end else begin
              state_r <= rw_r ? ST_RDATA : ST_WDATA;
              bit_r <= 3'h0;
            end
          end
        end
        // RQ5 write byte
        ST_WDATA: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_r <= bit_r + 3'h1;
            if (bit_r == qps_pkg::BIT_LAST) begin
              state_r <= ST_WACK;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            if (bit_r == 3'h0) begin
              bit_r <= 3'h1;
            end else begin
              state_r <= ST_WDATA;
              first_r <= 1'b0;
              bit_r <= 3'h0;
            end
          end
        end
        // RQ6 read byte
        ST_RDATA: begin
          if (scl_fall) begin
            bit_r <= bit_r + 3'h1;
            if (bit_r == qps_pkg::BIT_LAST) begin
              state_r <= ST_RACK;
            end
          end
        end
        // RQ3 master ack sample
        ST_RACK: begin
          // next byte starts only after the ack clock has fallen again
          if (scl_rise) begin
            if (sda_s) begin
              state_r <= ST_IGNORE;
            end else begin
              bit_r <= 3'h1;
            end
          end else if (scl_fall && bit_r == 3'h1) begin
            state_r <= ST_RDATA;
            bit_r <= 3'h0;
          end
        end
        ST_IGNORE: begin
          bit_r <= 3'h0;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // read byte load: request on the rise of the ack clock, shift on each clock fall
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_r <= 8'hff;
      rd_req <= 1'b0;
    end else begin
      rd_req <= 1'b0;
      if (((state_r == ST_ADDR_ACK && rw_r) || (state_r == ST_RACK && !sda_s)) && scl_rise) begin
        rd_req <= 1'b1;
      end
      if (rd_data_ok) begin
        tx_r <= rd_data;
      end else if (state_r == ST_RDATA && scl_fall) begin
        tx_r <= {tx_r[6:0], 1'b1};
      end
    end
  end

  // RQ8 clock stretch
  // RQ16 stretch bound
  // hold clock low in the ack slot until read data arrive or the limit runs out;
  // a slow register side therefore makes the master read ones from tx_r rather than hang the bus
  // the clock is only grabbed once it is low, never cut short in its high phase
  logic rd_wait_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_wait_r <= 1'b0;
    end else if (start_ev || stop_ev || str_done || rd_data_ok) begin
      rd_wait_r <= 1'b0;
    end else if (rd_req) begin
      rd_wait_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stretch_r <= 1'b0;
    end else if (start_ev || stop_ev || str_done) begin
      stretch_r <= 1'b0;
    end else begin
      stretch_r <= rd_wait_r && !scl_s;
    end
  end

  // RQ3 device ack drive
  // RQ9 no alert response
  // data line pulled low for ack slots and zero read bits only
  logic sda_low_nxt;
  always_comb begin
    sda_low_nxt = 1'b0;
    case (state_r)
      // ack from the eighth fall until the ninth fall, held through the ack clock high phase
      ST_ADDR_ACK: sda_low_nxt = (bit_r == 3'h1);
      ST_WACK: sda_low_nxt = (bit_r == 3'h1);
      ST_RDATA: sda_low_nxt = !tx_r[7];
      default: sda_low_nxt = 1'b0;
    endcase
  end

  // pin drivers and register-side strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_o <= 1'b0;
      sda_oe_n <= 1'b1;
      scl_o <= 1'b0;
      scl_oe_n <= 1'b1;
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
      wr_first <= 1'b0;
      wr_global <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_n <= !sda_low_nxt;
      scl_o <= 1'b0;
      scl_oe_n <= !stretch_r;
      wr_valid <= 1'b0;
      // RQ5 write byte out
      if (state_r == ST_WDATA && scl_rise && bit_r == qps_pkg::BIT_LAST) begin
        wr_valid <= 1'b1;
        wr_data <= {shift_r[6:0], sda_s};
        wr_first <= first_r;
        wr_global <= global_r;
      end
    end
  end

  // RQ15 power-up mode
  // status outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      ready <= 1'b0;
      busy <= 1'b0;
      pwrup_mode <= PWRUP_AUTO ? qps_pkg::MODE_AUTO : qps_pkg::MODE_SHUTDOWN;
    end else begin
      ready <= ready_r && strap_taken_r;
      busy <= (state_r != ST_IDLE) && (state_r != ST_IGNORE);
      pwrup_mode <= PWRUP_AUTO ? qps_pkg::MODE_AUTO : qps_pkg::MODE_SHUTDOWN;
    end
  end
endmodule // qps_i2c_slave

// file: verif/qps_i2c_slave_chk.sv
// assertion checker for the two-wire slave port
`timescale 1ns/1ps
module qps_i2c_slave_chk #(
  parameter int READY_CYCLES = 20,
  parameter int STRETCH_CYCLES = 8,
  parameter bit PWRUP_AUTO = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus drive
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  // side and status
  input wire logic wr_valid,
  input wire logic rd_req,
  input wire logic ready,
  input wire logic busy,
  input wire logic [1:0] pwrup_mode
);
  localparam logic [1:0] MODE_EXP = PWRUP_AUTO ? qps_pkg::MODE_AUTO : qps_pkg::MODE_SHUTDOWN;
  int str_n;
  int rdy_n;
  int rd_age;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // length of a clock stretch, so a stuck hold shows as a count
  always_ff @(posedge clk) begin
    str_n <= (rst || scl_oe_n) ? 0 : str_n + 1;
  end
  // cycles since the last read request, saturating
  always_ff @(posedge clk) begin
    rd_age <= (rst || rd_req) ? 0 : ((rd_age < 1000) ? rd_age + 1 : rd_age);
  end
  // cycles spent waiting for readiness
  always_ff @(posedge clk) begin
    rdy_n <= (rst || ready) ? 0 : rdy_n + 1;
  end
  AST_RST_QUIET: assert property ($past(rst) |-> scl_oe_n && sda_oe_n && !ready)
    else $error("bus driven straight after reset");
  AST_SDA_LOW: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  AST_SCL_LOW: assert property (scl_o == 1'b0)
    else $error("clock line driven high");
  AST_STRETCH: assert property (str_n <= STRETCH_CYCLES + 2)
    else $error("clock stretch too long");
  AST_READY: assert property (rdy_n <= READY_CYCLES + 8)
    else $error("ready late");
  AST_WR_PULSE: assert property (wr_valid |=> !wr_valid)
    else $error("write strobe too long");
  AST_WR_BUSY: assert property (wr_valid |-> busy)
    else $error("write outside addressed frame");
  AST_RD_PULSE: assert property (rd_req |=> !rd_req)
    else $error("read request too long");
  AST_STR_CAUSE: assert property ($fell(scl_oe_n) |-> rd_age <= 16)
    else $error("stretch without read request");
  AST_IDLE: assert property (!ready |-> sda_oe_n && !busy)
    else $error("traffic before ready");
  AST_MODE: assert property (!$past(rst) |-> pwrup_mode == MODE_EXP)
    else $error("power-up mode wrong");
  // main scenarios reached
  cover property (wr_valid && busy);
  cover property (rd_req);
  cover property (!scl_oe_n);
endmodule // qps_i2c_slave_chk

bind qps_i2c_slave qps_i2c_slave_chk #(.READY_CYCLES(READY_CYCLES),
  .STRETCH_CYCLES(STRETCH_CYCLES), .PWRUP_AUTO(PWRUP_AUTO)) qps_i2c_slave_chk_inst (
  .clk(clk), .rst(rst), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .wr_valid(wr_valid), .rd_req(rd_req), .ready(ready),
  .busy(busy), .pwrup_mode(pwrup_mode));

// file: verif/qps_host_model.sv
// behavioural bus master for the two-wire port
`timescale 1ns/1ps
module qps_host_model #(
  parameter int H = 6
) (
  // clock
  input wire logic clk,
  // resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // master drive, 1 releases the line
  output logic scl_m,
  output logic sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    sda_m <= 1'b1;
    hold(H);
    scl_m <= 1'b1;
    hold(H);
    sda_m <= 1'b0;
    hold(H);
    scl_m <= 1'b0;
    hold(H);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    hold(H);
    scl_m <= 1'b1;
    hold(H);
    sda_m <= 1'b1;
    hold(H);
  endtask
  // honour stretch, sample late in high phase
  task automatic bit_x(input logic b, output logic r);
    int n;
    n = 0;
    sda_m <= b;
    hold(H);
    scl_m <= 1'b1;
    hold(1);
    while (scl !== 1'b1 && n < 400) begin
      n++;
      hold(1);
    end
    hold(H);
    r = sda;
    scl_m <= 1'b0;
    // data moves only once the fall has settled, never looks like a frame edge
    hold(2);
  endtask
  // byte out msb first, then ack slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // byte in, master ack or nack after it
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~mack, r);
  endtask
endmodule // qps_host_model

// file: verif/qps_i2c_slave_test.sv
// self-checking bench for the two-wire slave port
`timescale 1ns/1ps
module qps_i2c_slave_test;
  localparam int RDY = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] strap = 4'ha;
  logic [7:0] rd_data = 8'h96;
  logic rd_data_ok = 1'b0;
  logic [9:0] rd_sh = 10'h000;
  logic scl, sda, scl_m, sda_m, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic wr_valid, wr_first, wr_global, rd_req, ready, busy, wf, wg;
  logic [7:0] wr_data, wd;
  logic [1:0] pwrup_mode;
  int wcnt = 0;
  int fails = 0;
  int checked = 0;
  always #20 clk = ~clk;
  // open-drain wires with pull-ups
  assign scl = scl_m & (scl_oe_n | scl_o);
  assign sda = sda_m & (sda_oe_n | sda_o);
  // register side answers late, so the port must stretch
  always @(posedge clk) begin
    rd_sh <= {rd_sh[8:0], rd_req === 1'b1};
    rd_data_ok <= rd_sh[9];
  end
  // capture of each written byte
  always @(posedge clk) begin
    if (wr_valid === 1'b1) begin
      wcnt <= wcnt + 1;
      wd <= wr_data;
      wf <= wr_first;
      wg <= wr_global;
    end
  end
  qps_i2c_slave #(.READY_CYCLES(RDY), .STRETCH_CYCLES(8), .PWRUP_AUTO(1'b1))
    qps_i2c_slave_inst (.clk(clk), .rst(rst), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .addr_strap_3(strap[3]), .addr_strap_2(strap[2]), .addr_strap_1(strap[1]),
    .addr_strap_0(strap[0]), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_first(wr_first), .wr_global(wr_global), .rd_data(rd_data),
    .rd_data_ok(rd_data_ok), .rd_req(rd_req), .ready(ready), .busy(busy),
    .pwrup_mode(pwrup_mode));
  qps_host_model qps_host_model_inst (.clk(clk), .scl(scl), .sda(sda),
    .scl_m(scl_m), .sda_m(sda_m));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one addressed write frame of up to two bytes
  task automatic wr(input logic [6:0] ad, input logic [7:0] d, output logic a);
    qps_host_model_inst.start();
    qps_host_model_inst.wbyte({ad, 1'b0}, a);
    if (a === 1'b1) qps_host_model_inst.wbyte(d, a);
  endtask
  // readiness and power-up mode; no traffic until ready
  task automatic t_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < RDY + 20) begin
      @(posedge clk);
      n++;
    end
    check({7'h0, ready}, 8'h1);
    check({6'h0, pwrup_mode}, {6'h0, qps_pkg::MODE_AUTO});
  endtask
  // strapped write, first flag on first byte only
  task automatic t_write();
    logic a;
    wr({qps_pkg::ADDR_FIXED, 4'ha}, 8'h5c, a);
    check({7'h0, a}, 8'h1);
    check(wd, 8'h5c);
    check({6'h0, wf, wg}, 8'h2);
    qps_host_model_inst.wbyte(8'ha3, a);
    check({wd[7:1], a}, 8'ha3);
    check({6'h0, wf, wg}, 8'h0);
    qps_host_model_inst.stop();
  endtask
  // global address used for writes only
  // broadcast write is taken and marked
  task automatic t_global();
    logic a;
    wr(qps_pkg::ADDR_GLOBAL, 8'h3c, a);
    check({7'h0, a}, 8'h1);
    check({wd[7:2], wf, wg}, 8'h3f);
    qps_host_model_inst.stop();
  endtask
  // only valid strap settings used
  // straps moved after capture: new address ignored, old one kept
  task automatic t_miss();
    logic a;
    int n;
    n = wcnt;
    strap <= 4'hb;
    wr({qps_pkg::ADDR_FIXED, 4'hb}, 8'h77, a);
    check({7'h0, a}, 8'h0);
    qps_host_model_inst.wbyte(8'h77, a);
    check(8'(wcnt - n), 8'h0);
    qps_host_model_inst.stop();
    wr({qps_pkg::ADDR_FIXED, 4'ha}, 8'h42, a);
    check({wd[7:1], a}, 8'h43);
    qps_host_model_inst.stop();
  endtask
  // two-byte read over a slow register side, strapped address only
  task automatic t_read();
    logic a;
    logic [7:0] d;
    qps_host_model_inst.start();
    qps_host_model_inst.wbyte({qps_pkg::ADDR_FIXED, 4'ha, 1'b1}, a);
    check({7'h0, a}, 8'h1);
    qps_host_model_inst.rbyte(1'b1, d);
    check(d, 8'h96);
    qps_host_model_inst.rbyte(1'b0, d);
    check(d, 8'h96);
    qps_host_model_inst.stop();
  endtask
  // restart in mid byte drops the partial byte
  task automatic t_abort();
    logic a;
    int n;
    qps_host_model_inst.start();
    qps_host_model_inst.wbyte({qps_pkg::ADDR_FIXED, 4'ha, 1'b0}, a);
    n = wcnt;
    for (int i = 0; i < 4; i++) qps_host_model_inst.bit_x(i[0], a);
    wr({qps_pkg::ADDR_FIXED, 4'ha}, 8'h11, a);
    qps_host_model_inst.stop();
    check(8'(wcnt - n), 8'h1);
    check(wd, 8'h11);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_ready();
    t_write();
    t_global();
    t_miss();
    t_read();
    t_abort();
    conclude();
  end
  // watchdog well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule // qps_i2c_slave_test
